// File: verilog/astr_pkg.sv
`default_nettype none
package astr_pkg;
   // Register word addresses
   localparam logic [2:0] A_MODE = 3'h0;
   localparam logic [2:0] A_CTRL0 = 3'h1;
   localparam logic [2:0] A_CTRL1 = 3'h2;
   localparam logic [2:0] A_BRG = 3'h3;
   localparam logic [2:0] A_TXBUF = 3'h4;
   localparam logic [2:0] A_RXLO = 3'h5;
   localparam logic [2:0] A_RXHI = 3'h6;
   localparam logic [2:0] A_IRQ = 3'h7;
   // Mode register fields
   localparam int MB_LEN = 0;
   localparam int MB_EXT = 3;
   localparam int MB_STOP = 4;
   localparam int MB_EVEN = 5;
   localparam int MB_PEN = 6;
   localparam int MB_SLEEP = 7;
   localparam logic [2:0] LEN7 = 3'h4;
   localparam logic [2:0] LEN8 = 3'h5;
   localparam logic [2:0] LEN9 = 3'h6;
   localparam logic [3:0] D7 = 4'h7;
   localparam logic [3:0] D8 = 4'h8;
   localparam logic [3:0] D9 = 4'h9;
   // Control 0 fields
   localparam int C0_RTS = 2;
   localparam int C0_IDLE = 3;
   localparam int C0_RXERR = 5;
   // Control 1 fields
   localparam int C1_TXP = 0;
   localparam int C1_TXE = 1;
   localparam int C1_RXP = 2;
   // Interrupt request register fields
   localparam int IR_TX = 0;
   localparam int IR_RX = 1;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h05;
   localparam logic [7:0] BRG_RST = 8'h00;
   // Frame and oversampling figures
   localparam logic [3:0] FRM = 4'hD;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID = 4'h7;
   typedef enum logic {TX_IDLE, TX_SHIFT} astr_tx_e;
   typedef enum logic {RX_IDLE, RX_RUN} astr_rx_e;
endpackage
`default_nettype wire

// File: verilog/astr_top.sv
// Decided for this implementation: strobed register access and the register offsets.
`default_nettype none
module astr_top
   import astr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_addr,
   input wire logic [8:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ext_clk,
   input wire logic i_serial_in,
   input wire logic i_peer_ready_in_n,
   output logic [8:0] o_rd_data,
   output logic o_serial_out_pin,
   output logic o_rx_ready_out_n,
   output logic o_tx_irq,
   output logic o_rx_irq
);
   typedef struct packed {
      logic [7:0] mode;
      logic rts_sel;
      logic rx_int_err;
      logic tx_permit;
      logic tx_empty;
      logic rx_permit;
      logic rx_full;
      logic oer;
      logic fer;
      logic per;
      logic [7:0] brg;
      logic [8:0] txbuf;
      logic [8:0] rxbuf;
      logic tx_irq;
      logic rx_irq;
      logic [8:0] rd_data;
      logic [1:0] s_ext;
      logic ext_d;
      logic [1:0] s_rx;
      logic [1:0] s_cts;
      logic [7:0] pre;
      astr_tx_e tx_st;
      logic [12:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_cnt;
      logic tx_end_d;
      logic tx_idle;
      logic txd;
      astr_rx_e rx_st;
      logic [12:0] rx_sh;
      logic [3:0] rx_bits;
      logic [3:0] rx_cnt;
      logic rts_n;
      logic rts_out;
   } astr_state_s;

   astr_state_s q_ff;
   astr_state_s nxt_q;
   logic tick;
   logic tx_start;
   logic rx_done;
   logic rx_load;
   logic rx_drop;
   logic rd_lo;
   logic [12:0] rx_al;
   logic [8:0] rx_data;
   logic rx_fe;
   logic rx_pe;
   logic rx_top;

   // Data bits per character
   function automatic logic [3:0] f_dbits(input logic [7:0] m);
      if (m[MB_LEN+:3] == LEN7) return D7;
      if (m[MB_LEN+:3] == LEN9) return D9;
      return D8;
   endfunction

   // Whole frame length in bits
   function automatic logic [3:0] f_total(input logic [7:0] m);
      return 4'h1 + f_dbits(m) + {3'h0, m[MB_PEN]} + (m[MB_STOP] ? 4'h2 : 4'h1);
   endfunction

   // Data mask for the selected length
   function automatic logic [8:0] f_mask(input logic [7:0] m);
      return 9'h1FF >> (D9 - f_dbits(m));
   endfunction

   // Parity bit for odd or even mode
   function automatic logic f_par(input logic [7:0] m, input logic [8:0] d);
      logic x;
      x = ^(d & f_mask(m));
      return m[MB_EVEN] ? x : ~x;
   endfunction

   // Frame image, LSB leaves first
   function automatic logic [12:0] f_frame(input logic [7:0] m, input logic [8:0] d);
      logic [12:0] f;
      logic [3:0] n;
      f = '1;
      n = f_dbits(m);
      for (int i = 0; i < 9; i++) begin
         if (i < int'(n)) f[i+1] = d[i];
      end
      f[0] = 1'b0;
      if (m[MB_PEN]) f[n+4'h1] = f_par(m, d);
      return f;
   endfunction

   // Received frame decoding
   always_comb begin
      rx_al = {q_ff.s_rx[1], q_ff.rx_sh[12:1]} >> (FRM - f_total(q_ff.mode));
      rx_data = rx_al[9:1] & f_mask(q_ff.mode);
      rx_pe = q_ff.mode[MB_PEN]
         && (rx_al[f_dbits(q_ff.mode)+4'h1] != f_par(q_ff.mode, rx_data));
      rx_fe = !rx_al[f_dbits(q_ff.mode)+4'h1+{3'h0, q_ff.mode[MB_PEN]}]
         || (q_ff.mode[MB_STOP]
         && !rx_al[f_dbits(q_ff.mode)+4'h2+{3'h0, q_ff.mode[MB_PEN]}]);
      rx_top = rx_data[f_dbits(q_ff.mode)-4'h1];
   end

   // Strobes and events of this cycle
   assign tick = (q_ff.mode[MB_EXT] ? (q_ff.s_ext[1] && !q_ff.ext_d) : 1'b1)
      && (q_ff.pre >= q_ff.brg);
   assign tx_start = tick && q_ff.tx_st == TX_IDLE && q_ff.tx_permit
      && !q_ff.tx_empty && !q_ff.s_cts[1];
   assign rx_done = q_ff.rx_st == RX_RUN && q_ff.rx_permit && tick
      && q_ff.rx_cnt == OVS_MID && q_ff.rx_bits == 4'h1;
   assign rx_drop = rx_done && q_ff.mode[MB_SLEEP] && !rx_top;
   assign rx_load = rx_done && !rx_drop;
   assign rd_lo = i_rd && i_addr == A_RXLO;

   always_comb begin
      nxt_q = q_ff;
      // Synchronisers and prescaler
      nxt_q.s_ext = {q_ff.s_ext[0], i_ext_clk};
      nxt_q.s_rx = {q_ff.s_rx[0], i_serial_in};
      nxt_q.s_cts = {q_ff.s_cts[0], i_peer_ready_in_n};
      nxt_q.ext_d = q_ff.s_ext[1];
      if (!q_ff.mode[MB_EXT] || (q_ff.s_ext[1] && !q_ff.ext_d)) begin
         nxt_q.pre = (q_ff.pre >= q_ff.brg) ? 8'h00 : q_ff.pre + 8'h01;
      end
      // Register writes
      if (i_wr) begin
         unique case (i_addr)
            A_MODE: nxt_q.mode = i_wr_data[7:0];
            A_CTRL0: begin
               nxt_q.rts_sel = i_wr_data[C0_RTS];
               nxt_q.rx_int_err = i_wr_data[C0_RXERR];
            end
            A_CTRL1: begin
               nxt_q.tx_permit = i_wr_data[C1_TXP];
               nxt_q.rx_permit = i_wr_data[C1_RXP];
               if (!i_wr_data[C1_RXP]) begin
                  nxt_q.rx_full = 1'b0;
                  nxt_q.oer = 1'b0;
                  nxt_q.fer = 1'b0;
                  nxt_q.per = 1'b0;
               end else if (!q_ff.rx_permit) begin
                  nxt_q.rts_n = 1'b0;
               end
            end
            A_BRG: nxt_q.brg = i_wr_data[7:0];
            A_TXBUF: begin
               nxt_q.txbuf = i_wr_data;
               nxt_q.tx_empty = 1'b0;
            end
            A_IRQ: begin
               nxt_q.tx_irq = i_wr_data[IR_TX];
               nxt_q.rx_irq = i_wr_data[IR_RX];
            end
            default: ;
         endcase
      end
      // Low byte read empties the buffer
      if (rd_lo) begin
         nxt_q.rx_full = 1'b0;
         nxt_q.fer = 1'b0;
         nxt_q.per = 1'b0;
         if (q_ff.rx_permit) nxt_q.rts_n = 1'b0;
      end
      // Transmit sequencer
      nxt_q.tx_end_d = q_ff.tx_st == TX_IDLE;
      if (q_ff.tx_st == TX_IDLE && !q_ff.tx_end_d) nxt_q.tx_idle = 1'b1;
      unique case (q_ff.tx_st)
         TX_IDLE: begin
            if (tx_start) begin
               nxt_q.tx_st = TX_SHIFT;
               nxt_q.tx_sh = f_frame(q_ff.mode, q_ff.txbuf);
               nxt_q.tx_bits = f_total(q_ff.mode);
               nxt_q.tx_cnt = 4'h0;
               nxt_q.tx_empty = 1'b1;
               nxt_q.tx_idle = 1'b0;
               if (!q_ff.tx_empty) nxt_q.tx_irq = 1'b1;
            end
         end
         TX_SHIFT: begin
            if (tick) begin
               nxt_q.tx_cnt = q_ff.tx_cnt + 4'h1;
               if (q_ff.tx_cnt == OVS_LAST) begin
                  nxt_q.tx_sh = {1'b1, q_ff.tx_sh[12:1]};
                  nxt_q.tx_bits = q_ff.tx_bits - 4'h1;
                  if (q_ff.tx_bits == 4'h1) nxt_q.tx_st = TX_IDLE;
               end
            end
         end
      endcase
      nxt_q.txd = (nxt_q.tx_st == TX_SHIFT) ? nxt_q.tx_sh[0] : 1'b1;
      // Receive sequencer
      unique case (q_ff.rx_st)
         RX_IDLE: begin
            if (q_ff.rx_permit && tick && !q_ff.s_rx[1]) begin
               nxt_q.rx_st = RX_RUN;
               nxt_q.rx_cnt = 4'h0;
               nxt_q.rx_bits = f_total(q_ff.mode);
               nxt_q.rts_n = 1'b1;
            end
         end
         RX_RUN: begin
            if (!q_ff.rx_permit) begin
               nxt_q.rx_st = RX_IDLE;
            end else if (tick) begin
               nxt_q.rx_cnt = q_ff.rx_cnt + 4'h1;
               if (q_ff.rx_cnt == OVS_MID) begin
                  nxt_q.rx_sh = {q_ff.s_rx[1], q_ff.rx_sh[12:1]};
                  nxt_q.rx_bits = q_ff.rx_bits - 4'h1;
                  if (q_ff.rx_bits == 4'h1) nxt_q.rx_st = RX_IDLE;
                  if (q_ff.rx_bits == f_total(q_ff.mode) && q_ff.s_rx[1]) begin
                     nxt_q.rx_st = RX_IDLE;
                  end
               end
            end
         end
      endcase
      // Buffer load: hardware sets win over clears
      if (rx_load) begin
         nxt_q.rxbuf = rx_data;
         nxt_q.rx_full = 1'b1;
         nxt_q.oer = nxt_q.oer || q_ff.rx_full;
         nxt_q.fer = rx_fe;
         nxt_q.per = rx_pe;
         if (!q_ff.rx_int_err || q_ff.rx_full || rx_fe || rx_pe) begin
            nxt_q.rx_irq = 1'b1;
         end
      end
      // Read data, one cycle after the strobe
      nxt_q.rd_data = 9'h000;
      if (i_rd) begin
         unique case (i_addr)
            A_MODE: nxt_q.rd_data = {1'b0, q_ff.mode};
            A_CTRL0: begin
               nxt_q.rd_data[C0_RTS] = q_ff.rts_sel;
               nxt_q.rd_data[C0_IDLE] = q_ff.tx_idle;
               nxt_q.rd_data[C0_RXERR] = q_ff.rx_int_err;
            end
            A_CTRL1: nxt_q.rd_data = {1'b0, q_ff.oer || q_ff.fer || q_ff.per,
               q_ff.per, q_ff.fer, q_ff.oer, q_ff.rx_full, q_ff.rx_permit,
               q_ff.tx_empty, q_ff.tx_permit};
            A_BRG: nxt_q.rd_data = {1'b0, q_ff.brg};
            A_TXBUF: nxt_q.rd_data = q_ff.txbuf;
            A_RXLO: nxt_q.rd_data = {1'b0, q_ff.rxbuf[7:0]};
            A_RXHI: nxt_q.rd_data = {8'h00, q_ff.rxbuf[8]};
            A_IRQ: nxt_q.rd_data = {7'h00, q_ff.rx_irq, q_ff.tx_irq};
            default: ;
         endcase
      end
      // Ready level rts_n stays high while permit is off; the output follows it only with rts_sel set
      if (!nxt_q.rx_permit) nxt_q.rts_n = 1'b1;
      nxt_q.rts_out = nxt_q.rts_sel ? nxt_q.rts_n : 1'b0;
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_ff <= '0;
         q_ff.mode <= MODE_RST;
         q_ff.brg <= BRG_RST;
         q_ff.tx_empty <= 1'b1;
         q_ff.tx_end_d <= 1'b1;
         q_ff.tx_idle <= 1'b1;
         q_ff.txd <= 1'b1;
         q_ff.s_rx <= 2'h3;
         q_ff.s_cts <= 2'h3;
         q_ff.rts_n <= 1'b1;
         q_ff.tx_st <= TX_IDLE;
         q_ff.rx_st <= RX_IDLE;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_rd_data = q_ff.rd_data;
   assign o_serial_out_pin = q_ff.txd;
   assign o_rx_ready_out_n = q_ff.rts_out;
   assign o_tx_irq = q_ff.tx_irq;
   assign o_rx_irq = q_ff.rx_irq;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_frame_go;
      tx_start;
   endsequence
   sequence s_busy_mid;
      q_ff.tx_st == TX_SHIFT && q_ff.tx_bits > 4'h1;
   endsequence

   AST_TX_COND: assert property ($rose(q_ff.tx_st == TX_SHIFT) |->
      $past(q_ff.tx_permit) && !$past(q_ff.tx_empty) && !$past(q_ff.s_cts[1]))
      else $error("frame started without start condition");
   AST_TX_EMPTY: assert property (s_frame_go |=> q_ff.tx_empty && q_ff.tx_irq)
      else $error("buffer empty or request not set on load");
   AST_TX_HOLD: assert property (s_busy_mid |=> q_ff.tx_st == TX_SHIFT)
      else $error("frame aborted before its last bit");
   AST_TX_IDLE: assert property ($rose(q_ff.tx_st == TX_IDLE) && !tx_start
      |=> q_ff.tx_idle)
      else $error("idle flag not set after frame end");
   AST_TX_IDLE_CLR: assert property (s_frame_go |=> !q_ff.tx_idle)
      else $error("idle flag not cleared on start");
   AST_TX_LINE: assert property (q_ff.tx_st == TX_IDLE |=> ##1 $past(o_serial_out_pin)
      || $past(q_ff.tx_st == TX_SHIFT))
      else $error("line not high while idle");
   AST_RX_OVR: assert property (rx_load && q_ff.rx_full |=> q_ff.oer ##1 (q_ff.oer
      || $past(i_wr && i_addr == A_CTRL1 && !i_wr_data[C1_RXP])))
      else $error("overrun not set on load while full");
   AST_RX_OVR_KEEP: assert property (rd_lo && !i_wr && q_ff.oer |=> q_ff.oer)
      else $error("overrun cleared by buffer read");
   AST_RX_ERR_CLR: assert property (rd_lo && !rx_load |=> !q_ff.fer && !q_ff.per)
      else $error("error flags not cleared by buffer read");
   AST_RX_SLEEP: assert property (rx_drop && !i_wr && !rd_lo |=>
      q_ff.rxbuf == $past(q_ff.rxbuf) && q_ff.rx_full == $past(q_ff.rx_full)
      && q_ff.rx_irq == $past(q_ff.rx_irq))
      else $error("sleeping receiver took a data frame");
   AST_RX_IRQ: assert property (rx_load && !q_ff.rx_int_err |=> q_ff.rx_irq)
      else $error("receive request missing");
   AST_RTS_OFF: assert property (q_ff.rts_sel && !q_ff.rx_permit |-> o_rx_ready_out_n)
      else $error("ready output low while receive off");
endmodule
`default_nettype wire

// File: tb/astr_peer.sv
`default_nettype none
// Far-end serial station: frames out on o_line, frames in from i_line
module astr_peer #(
   parameter int BIT = 32
) (
   input wire logic i_clk,
   input wire logic i_line,
   output logic o_line
);
   timeunit 1ns;
   timeprecision 1ns;

   // Line idles high between frames
   initial o_line = 1'b1;

   // Drive one bit for a full bit time
   task automatic hold(input logic v);
      o_line <= v;
      repeat (BIT) @(posedge i_clk);
   endtask

   // Start, data LSB first, parity, stops; e0 flips parity, e1 drops stop
   task automatic send(input logic [8:0] d, input logic [7:0] m, input logic [1:0] e);
      int nb;
      logic p;
      nb = int'(m[2:0]) + 3;
      p = ^(d & ~(9'h1FF << nb));
      @(posedge i_clk);
      hold(1'b0);
      for (int i = 0; i < nb; i++) hold(d[i]);
      if (m[6]) hold(p ^ ~m[5] ^ e[0]);
      hold(~e[1]);
      if (m[4]) hold(1'b1);
      hold(1'b1);
   endtask

   // Centre-sampled receive; ok low on timeout, bad start, parity or stop
   task automatic recv(input logic [7:0] m, output logic [8:0] d, output logic ok);
      int nb;
      int n;
      logic p;
      nb = int'(m[2:0]) + 3;
      d = 9'h000;
      n = 0;
      while (i_line !== 1'b0 && n < 20 * BIT) begin
         @(posedge i_clk);
         n++;
      end
      repeat (BIT / 2) @(posedge i_clk);
      ok = (n < 20 * BIT) && (i_line === 1'b0);
      for (int i = 0; i < nb; i++) begin
         repeat (BIT) @(posedge i_clk);
         d[i] = i_line;
      end
      p = ^d;
      if (m[6]) begin
         repeat (BIT) @(posedge i_clk);
         ok &= (i_line === (p ^ ~m[5]));
      end
      for (int i = 0; i <= int'(m[4]); i++) begin
         repeat (BIT) @(posedge i_clk);
         ok &= (i_line === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench
   import astr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_rst, i_wr, i_rd, i_ext_clk, i_peer_ready_in_n, i_serial_in;
   logic [2:0] i_addr;
   logic [8:0] i_wr_data, o_rd_data, d;
   logic o_serial_out_pin, o_rx_ready_out_n, o_tx_irq, o_rx_irq;
   int mismatches, n_checks;
   logic [8:0] rst_exp [4] = '{9'h005, 9'h008, 9'h002, 9'h000};
   logic [7:0] modes [3] = '{8'h64, 8'h56, 8'h45};

   astr_top u_dut (.i_clk, .i_rst, .i_addr, .i_wr_data, .i_wr, .i_rd, .i_ext_clk,
      .i_serial_in, .i_peer_ready_in_n, .o_rd_data, .o_serial_out_pin,
      .o_rx_ready_out_n, .o_tx_irq, .o_rx_irq);
   astr_peer #(.BIT(32)) u_peer (.i_clk(i_clk), .i_line(o_serial_out_pin),
      .o_line(i_serial_in));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [8:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Read and compare the data of the following cycle
   task automatic rc(input logic [2:0] a, input logic [8:0] e, input logic [8:0] m = 9'h1FF);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rd_data & m, e);
   endtask

   // Pin level once registered outputs have settled
   task automatic pin(ref logic s, input logic e);
      repeat (2) @(negedge i_clk);
      chk(9'(s), 9'(e));
   endtask

   task automatic get(input logic [7:0] m, output logic [8:0] v);
      logic ok;
      u_peer.recv(m, v, ok);
      chk(9'(ok), 9'h001);
      if (ok !== 1'b1) finish_test();
   endtask

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // External rate clock at half the system rate
   initial begin
      i_ext_clk = 1'b0;
      forever @(posedge i_clk) i_ext_clk <= ~i_ext_clk;
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge i_clk);
      mismatches++;
      finish_test();
   end

   initial begin
      {i_wr, i_rd, i_rst, i_peer_ready_in_n} = 4'h3;
      i_addr = 3'h0;
      i_wr_data = 9'h000;
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int a = 0; a < 4; a++) rc(3'(a), rst_exp[a]);
      // Transmit held while the peer is not ready
      wr(A_BRG, 9'h001);
      wr(A_CTRL1, 9'h001);
      wr(A_TXBUF, 9'h05A);
      rc(A_CTRL1, 9'h001);
      repeat (100) @(posedge i_clk);
      i_peer_ready_in_n <= 1'b0;
      chk(9'(o_serial_out_pin), 9'h001);
      // Back to back frames; permit and peer dropped mid-frame
      fork
         begin
            get(MODE_RST, d);
            chk(d, 9'h05A);
            get(MODE_RST, d);
            chk(d, 9'h0C3);
         end
         begin
            repeat (40) @(posedge i_clk);
            chk(9'(o_tx_irq), 9'h001);
            rc(A_CTRL1, 9'h003);
            wr(A_TXBUF, 9'h0C3);
            repeat (400) @(posedge i_clk);
            rc(A_CTRL0, 9'h000);
            wr(A_CTRL1, 9'h000);
            i_peer_ready_in_n <= 1'b1;
         end
      join
      repeat (40) @(posedge i_clk);
      rc(A_CTRL0, 9'h008);
      wr(A_TXBUF, 9'h011);
      repeat (200) @(posedge i_clk);
      chk(9'(o_serial_out_pin), 9'h001);
      rc(A_CTRL1, 9'h000);
      wr(A_CTRL1, 9'h001);
      i_peer_ready_in_n <= 1'b0;
      get(MODE_RST, d);
      chk(d, 9'h011);
      // Each length, parity sense and stop count
      foreach (modes[i]) begin
         wr(A_MODE, 9'(modes[i]));
         wr(A_TXBUF, 9'h1B6);
         get(modes[i], d);
         chk(d, 9'h1B6 & ~(9'h1FF << (int'(modes[i][2:0]) + 3)));
      end
      // External rate source, one tick per external rising edge
      wr(A_BRG, 9'h000);
      wr(A_MODE, 9'h00D);
      wr(A_TXBUF, 9'h0A5);
      get(8'h0D, d);
      chk(d, 9'h0A5);
      wr(A_BRG, 9'h001);
      // Reception with the ready output selected
      wr(A_MODE, 9'(MODE_RST));
      wr(A_CTRL0, 9'h004);
      wr(A_IRQ, 9'h000);
      pin(o_rx_ready_out_n, 1'b1);
      wr(A_CTRL1, 9'h004);
      pin(o_rx_ready_out_n, 1'b0);
      u_peer.send(9'h03C, MODE_RST, 2'b00);
      pin(o_rx_ready_out_n, 1'b1);
      pin(o_rx_irq, 1'b1);
      rc(A_CTRL1, 9'h00E);
      rc(A_RXLO, 9'h03C);
      pin(o_rx_ready_out_n, 1'b0);
      // Overrun, then the clearing paths
      u_peer.send(9'h011, MODE_RST, 2'b00);
      u_peer.send(9'h022, MODE_RST, 2'b00);
      rc(A_CTRL1, 9'h09E);
      rc(A_RXLO, 9'h022);
      rc(A_CTRL1, 9'h096);
      wr(A_CTRL1, 9'h000);
      rc(A_CTRL1, 9'h002);
      u_peer.send(9'h077, MODE_RST, 2'b00);
      rc(A_CTRL1, 9'h002);
      wr(A_CTRL1, 9'h004);
      u_peer.send(9'h055, MODE_RST, 2'b10);
      rc(A_CTRL1, 9'h0AE);
      rc(A_RXLO, 9'h055);
      rc(A_CTRL1, 9'h006);
      // Parity error with requests on errors only
      wr(A_MODE, 9'h065);
      wr(A_CTRL0, 9'h024);
      wr(A_IRQ, 9'h000);
      u_peer.send(9'h066, 8'h65, 2'b00);
      pin(o_rx_irq, 1'b0);
      rc(A_RXLO, 9'h066);
      u_peer.send(9'h066, 8'h65, 2'b01);
      pin(o_rx_irq, 1'b1);
      rc(A_CTRL1, 9'h0CE);
      wr(A_CTRL1, 9'h000);
      rc(A_CTRL1, 9'h002);
      rc(A_RXLO, 9'h066);
      // Sleep drops frames whose top bit is clear
      wr(A_CTRL1, 9'h004);
      wr(A_MODE, 9'h085);
      wr(A_CTRL0, 9'h004);
      wr(A_IRQ, 9'h000);
      u_peer.send(9'h005, 8'h85, 2'b00);
      rc(A_CTRL1, 9'h006);
      pin(o_rx_irq, 1'b0);
      u_peer.send(9'h085, 8'h85, 2'b00);
      rc(A_RXLO, 9'h085);
      pin(o_rx_irq, 1'b1);
      // Nine-bit character, top bit in the high byte
      wr(A_MODE, 9'h006);
      u_peer.send(9'h1A5, 8'h06, 2'b00);
      rc(A_RXHI, 9'h001);
      rc(A_RXLO, 9'h0A5);
      finish_test();
   end
endmodule
`default_nettype wire
